// ### rtl/cvt_pkg.sv
// Constants and carrier types for the vertical timing and address block.
package cvt_pkg;
	localparam logic [7:0] IDX_VTOTAL = 8'h06;
	localparam logic [7:0] IDX_OVERFLOW = 8'h07;
	localparam logic [7:0] IDX_MAXSCAN = 8'h09;
	localparam logic [7:0] IDX_VRS = 8'h10;
	localparam logic [7:0] IDX_VRE = 8'h11;
	localparam logic [7:0] IDX_VDE = 8'h12;
	localparam logic [7:0] IDX_PITCH = 8'h13;
	localparam logic [7:0] IDX_ULINE = 8'h14;
	localparam logic [7:0] IDX_VBS = 8'h15;
	localparam logic [7:0] IDX_VBE = 8'h16;
	localparam logic [7:0] IDX_MODE = 8'h17;
	localparam logic [7:0] IDX_LCMP = 8'h18;
	localparam logic [7:0] IDX_PROT_LAST = 8'h07;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// Retrace end control fields.
	localparam int VRE_WP = 7;
	localparam int VRE_REF5 = 6;
	localparam int VRE_IRQ_OFF = 5;
	localparam int VRE_IRQ_RUN = 4;
	// Overflow fields.
	localparam int OVF_VT8 = 0;
	localparam int OVF_VDE8 = 1;
	localparam int OVF_VRS8 = 2;
	localparam int OVF_VBS8 = 3;
	localparam int OVF_LC8 = 4;
	localparam int OVF_VT9 = 5;
	localparam int OVF_VDE9 = 6;
	localparam int OVF_VRS9 = 7;
	// Maximum scan line fields.
	localparam int MSL_VBS9 = 5;
	localparam int MSL_LC9 = 6;
	// Underline and mode control fields.
	localparam int UL_DWORD = 6;
	localparam int UL_CNT4 = 5;
	localparam int MC_HWRST = 7;
	localparam int MC_BYTE = 6;
	localparam int MC_WRAP = 5;
	localparam int MC_CNT2 = 3;
	localparam int MC_VDIV2 = 2;
	localparam int MC_SEL14 = 1;
	localparam int MC_COMPAT = 0;
	// Extension lock fields.
	localparam int LOCK_VTIME = 0;
	localparam int LOCK_MODE = 5;
	localparam logic [2:0] REFRESH_NORMAL = 3'h3;
	localparam logic [2:0] REFRESH_SLOW = 3'h5;
	typedef struct packed {
		logic index_wr;
		logic data_wr;
		logic data_rd;
		logic [7:0] wdata;
	} cvt_req_t;
endpackage : cvt_pkg

// ### rtl/cvt_vtiming.sv
// Vertical timing, retrace interrupt, refresh and memory address control.
// Notes on behaviour
// - Write-protect bit blocks writes to indices 00H-07H, except line compare bit 8.
// - Three refresh cycles per scan line, or five when refresh-select is set.
// - Retrace interrupt enable bit is active low: 0 enables, 1 suppresses.
// - Writing 0 to clear bit resets flag; with 1, bottom border raises it.
// - Vertical sync ends when low four line-count bits match retrace-end field.
// - Retrace start is ten bits: low byte here, bits 8 and 9 in overflow.
// - Legacy mode reads return light pen high six bits and low eight bits.
// - Display ends at ten-bit line count; bits 8, 9 at overflow 1 and 6.
// - Next row start is current start plus K times offset, K 2 byte, 4 word or 8 dword.
// - Address counter steps every character clock, or every second or fourth.
// - Underline drawn on row-scan line matching the five-bit underline field.
// - Blank start is ten bits, value plus one; bit 8 overflow, bit 9 max-scan.
// - Vertical blank ends when line count matches eight-bit end value.
// - Hardware-reset bit low holds horizontal and vertical retrace outputs inactive.
// - Lock bit 5 blocks mode writes; lock bit 0 blocks display-end and blank writes.
// - Word mode shifts pins one place, dword two with bits 12, 13 low.
// - Dword bit selects doubleword; otherwise mode bit 6 picks word or byte.
// - In word mode wrap bit puts counter bit 15 or 13 on pin 0.
// - Vertical counter steps on every retrace, or every second when selected.
// - Pin 14 carries row-scan bit 1 or counter bit 14.
// - Compatibility bit low puts row-scan bit 0 on pin 13 during display.
// - Line compare match clears the internal line address counter.
`timescale 1ns/1ps
module cvt_vtiming
	import cvt_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire cvt_req_t req_i,
	input wire logic [7:0] ext_lock_i,
	input wire logic legacy_mode_i,
	input wire logic [13:0] lpen_i,
	input wire logic char_tick_i,
	input wire logic hretrace_i,
	output logic [7:0] rdata_o,
	output logic hsync_o,
	output logic vsync_o,
	output logic vblank_o,
	output logic vdisp_o,
	output logic irq_o,
	output logic refresh_o,
	output logic underline_o,
	output logic [15:0] mem_addr_o
);
	logic [7:0] index;
	logic [7:0] vertical_total, overflow_bits, max_scan_line, retrace_start_low;
	logic [7:0] vertical_retrace_end_ctrl, vertical_display_end_low, row_pitch_offset;
	logic [7:0] underline_and_dword_ctrl, vertical_blank_start_low, vertical_blank_end;
	logic [7:0] timing_mode_control, split_line_compare_low;
	logic wp, hr_q, half, line_start, vtick, vsync_st, irq_flag, clr_wr;
	logic [9:0] vcount, next_vcount, vt10, vrs10, vde10, vbs10, lc10;
	logic [4:0] row_scan;
	logic [15:0] row_start, next_row_start, ma_cnt, step, mapped, pins;
	logic [1:0] div;
	logic [2:0] refresh_left;
	logic dword, word, lc_hit, wrap_hit, adv;

	assign wp = vertical_retrace_end_ctrl[VRE_WP];
	assign clr_wr = req_i.data_wr && index == IDX_VRE && !req_i.wdata[VRE_IRQ_RUN];

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			index <= RST_REG;
		end else if (req_i.index_wr) begin
			index <= req_i.wdata;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vertical_total <= RST_REG;
			overflow_bits <= RST_REG;
			max_scan_line <= RST_REG;
			retrace_start_low <= RST_REG;
			vertical_retrace_end_ctrl <= RST_REG;
			vertical_display_end_low <= RST_REG;
			row_pitch_offset <= RST_REG;
			underline_and_dword_ctrl <= RST_REG;
			vertical_blank_start_low <= RST_REG;
			vertical_blank_end <= RST_REG;
			timing_mode_control <= RST_REG;
			split_line_compare_low <= RST_REG;
		end else if (req_i.data_wr) begin
			case (index)
				IDX_VTOTAL: begin
					if (!wp) begin
						vertical_total <= req_i.wdata;
					end
				end
				IDX_OVERFLOW: begin
					if (!wp) begin
						overflow_bits <= req_i.wdata;
					end else begin
						overflow_bits[OVF_LC8] <= req_i.wdata[OVF_LC8];
					end
				end
				IDX_MAXSCAN: max_scan_line <= req_i.wdata;
				IDX_VRS: retrace_start_low <= req_i.wdata;
				IDX_VRE: vertical_retrace_end_ctrl <= req_i.wdata;
				IDX_VDE: begin
					if (!ext_lock_i[LOCK_VTIME]) begin
						vertical_display_end_low <= req_i.wdata;
					end
				end
				IDX_PITCH: row_pitch_offset <= req_i.wdata;
				IDX_ULINE: underline_and_dword_ctrl <= req_i.wdata;
				IDX_VBS: begin
					if (!ext_lock_i[LOCK_VTIME]) begin
						vertical_blank_start_low <= req_i.wdata;
					end
				end
				IDX_VBE: begin
					if (!ext_lock_i[LOCK_VTIME]) begin
						vertical_blank_end <= req_i.wdata;
					end
				end
				IDX_MODE: begin
					if (!ext_lock_i[LOCK_MODE]) begin
						timing_mode_control <= req_i.wdata;
					end
				end
				IDX_LCMP: split_line_compare_low <= req_i.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= RST_DATA;
		end else if (req_i.data_rd) begin
			case (index)
				IDX_VTOTAL: rdata_o <= vertical_total;
				IDX_OVERFLOW: rdata_o <= overflow_bits;
				IDX_MAXSCAN: rdata_o <= max_scan_line;
				IDX_VRS: rdata_o <= legacy_mode_i ? {2'h0, lpen_i[13:8]} : retrace_start_low;
				IDX_VRE: rdata_o <= legacy_mode_i ? lpen_i[7:0] : vertical_retrace_end_ctrl;
				IDX_VDE: rdata_o <= vertical_display_end_low;
				IDX_PITCH: rdata_o <= row_pitch_offset;
				IDX_ULINE: rdata_o <= underline_and_dword_ctrl;
				IDX_VBS: rdata_o <= vertical_blank_start_low;
				IDX_VBE: rdata_o <= vertical_blank_end;
				IDX_MODE: rdata_o <= timing_mode_control;
				IDX_LCMP: rdata_o <= split_line_compare_low;
				default: rdata_o <= RD_UNMAPPED;
			endcase
		end
	end

	assign vrs10 = {overflow_bits[OVF_VRS9], overflow_bits[OVF_VRS8], retrace_start_low};
	assign vde10 = {overflow_bits[OVF_VDE9], overflow_bits[OVF_VDE8], vertical_display_end_low};
	assign vbs10 = {max_scan_line[MSL_VBS9], overflow_bits[OVF_VBS8], vertical_blank_start_low};
	assign vt10 = {overflow_bits[OVF_VT9], overflow_bits[OVF_VT8], vertical_total};
	assign lc10 = {max_scan_line[MSL_LC9], overflow_bits[OVF_LC8], split_line_compare_low};

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hr_q <= 1'b0;
		end else begin
			hr_q <= hretrace_i;
		end
	end

	assign line_start = hretrace_i && !hr_q;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			half <= 1'b0;
		end else if (line_start) begin
			half <= !half;
		end
	end

	assign vtick = line_start && (!timing_mode_control[MC_VDIV2] || half);
	assign wrap_hit = vcount == vt10 + 10'h001;

	always_comb begin
		next_vcount = wrap_hit ? 10'h000 : vcount + 10'h001;
	end

	assign lc_hit = next_vcount == lc10;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vcount <= 10'h000;
		end else if (vtick) begin
			vcount <= next_vcount;
		end
	end

	// sync end on low four bits.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vsync_st <= 1'b0;
		end else if (vtick) begin
			if (next_vcount == vrs10) begin
				vsync_st <= 1'b1;
			end else if (next_vcount[3:0] == vertical_retrace_end_ctrl[3:0]) begin
				vsync_st <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hsync_o <= 1'b0;
			vsync_o <= 1'b0;
		end else begin
			hsync_o <= hretrace_i && timing_mode_control[MC_HWRST];
			vsync_o <= vsync_st && timing_mode_control[MC_HWRST];
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vblank_o <= 1'b0;
			vdisp_o <= 1'b0;
		end else if (vtick) begin
			if (next_vcount == vbs10 + 10'h001) begin
				vblank_o <= 1'b1;
			end else if (next_vcount[7:0] == vertical_blank_end) begin
				vblank_o <= 1'b0;
			end
			vdisp_o <= next_vcount <= vde10;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_flag <= 1'b0;
		end else if (vtick && next_vcount == vde10 + 10'h001 && vertical_retrace_end_ctrl[VRE_IRQ_RUN]) begin
			irq_flag <= 1'b1;
		end else if (clr_wr) begin
			irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_flag && !vertical_retrace_end_ctrl[VRE_IRQ_OFF];
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			refresh_left <= 3'h0;
			refresh_o <= 1'b0;
		end else if (line_start) begin
			refresh_left <= vertical_retrace_end_ctrl[VRE_REF5] ? REFRESH_SLOW : REFRESH_NORMAL;
			refresh_o <= 1'b0;
		end else begin
			refresh_o <= char_tick_i && refresh_left != 3'h0;
			if (char_tick_i && refresh_left != 3'h0) begin
				refresh_left <= refresh_left - 3'h1;
			end
		end
	end

	assign dword = underline_and_dword_ctrl[UL_DWORD];
	assign word = !dword && !timing_mode_control[MC_BYTE];

	always_comb begin
		step = {8'h00, row_pitch_offset} << (dword ? 3 : word ? 2 : 1);
		if (wrap_hit || lc_hit) begin
			next_row_start = 16'h0000;
		end else if (row_scan == max_scan_line[4:0]) begin
			next_row_start = row_start + step;
		end else begin
			next_row_start = row_start;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			row_start <= 16'h0000;
			row_scan <= 5'h00;
		end else if (vtick) begin
			row_start <= next_row_start;
			if (wrap_hit || lc_hit || row_scan == max_scan_line[4:0]) begin
				row_scan <= 5'h00;
			end else begin
				row_scan <= row_scan + 5'h01;
			end
		end
	end

	assign adv = underline_and_dword_ctrl[UL_CNT4] ? div == 2'h3 :
		timing_mode_control[MC_CNT2] ? div[0] : 1'b1;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div <= 2'h0;
			ma_cnt <= 16'h0000;
		end else if (vtick) begin
			div <= 2'h0;
			ma_cnt <= next_row_start;
		end else if (char_tick_i) begin
			div <= div + 2'h1;
			if (adv) begin
				ma_cnt <= ma_cnt + 16'h0001;
			end
		end
	end

	always_comb begin
		if (dword) begin
			mapped = {ma_cnt[13:0], ma_cnt[13], ma_cnt[12]};
		end else if (word) begin
			mapped = {ma_cnt[14:0], timing_mode_control[MC_WRAP] ? ma_cnt[15] : ma_cnt[13]};
		end else begin
			mapped = ma_cnt;
		end
		pins = mapped;
		pins[14] = timing_mode_control[MC_SEL14] ? mapped[14] : row_scan[1];
		pins[13] = (!timing_mode_control[MC_COMPAT] && vdisp_o) ? row_scan[0] : mapped[13];
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_addr_o <= 16'h0000;
			underline_o <= 1'b0;
		end else begin
			mem_addr_o <= pins;
			underline_o <= row_scan == underline_and_dword_ctrl[4:0];
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_border;
		vtick && next_vcount == vde10 + 10'h001 && vertical_retrace_end_ctrl[VRE_IRQ_RUN];
	endsequence
	sequence s_irq_up;
		##1 irq_flag ##1 (irq_o == !vertical_retrace_end_ctrl[VRE_IRQ_OFF] || $changed(vertical_retrace_end_ctrl));
	endsequence

	a_wp_blocks_vt: assert property (req_i.data_wr && index == IDX_VTOTAL && wp |=> $stable(vertical_total))
		else $error("protected vertical total changed");
	a_lc_bit_free: assert property (req_i.data_wr && index == IDX_OVERFLOW && wp
		|=> overflow_bits[OVF_LC8] == $past(req_i.wdata[OVF_LC8]))
		else $error("line compare bit not written");
	a_refresh_load: assert property (line_start |=> refresh_left == ($past(vertical_retrace_end_ctrl[VRE_REF5]) ? 3'h5 : 3'h3))
		else $error("refresh count wrong");
	a_irq_raise: assert property (s_border |-> s_irq_up)
		else $error("interrupt not raised at bottom border");
	a_irq_hold: assert property (irq_flag && !clr_wr |=> irq_flag)
		else $error("interrupt dropped without clear");
	a_irq_mask: assert property (vertical_retrace_end_ctrl[VRE_IRQ_OFF] && $past(vertical_retrace_end_ctrl[VRE_IRQ_OFF])
		|=> !irq_o)
		else $error("masked interrupt asserted");
	a_retrace_gate: assert property (!timing_mode_control[MC_HWRST] |=> !hsync_o && !vsync_o)
		else $error("retrace not held inactive");
	a_mode_lock: assert property (req_i.data_wr && index == IDX_MODE && ext_lock_i[LOCK_MODE]
		|=> $stable(timing_mode_control))
		else $error("locked mode register changed");
	a_legacy_read: assert property (req_i.data_rd && index == IDX_VRE && legacy_mode_i
		|=> rdata_o == $past(lpen_i[7:0]))
		else $error("light pen low byte not returned");
	a_pin14_sel: assert property (!timing_mode_control[MC_SEL14] |=> mem_addr_o[14] == $past(row_scan[1]))
		else $error("pin 14 not row scan bit");
endmodule : cvt_vtiming

// ### verification/cvt_raster_model.sv
// Raster source model: character clock ticks and horizontal retrace level.
`timescale 1ns/1ps
module cvt_raster_model #(
	parameter int LINE_CYC = 40,
	parameter int TICK_DIV = 4,
	parameter int RETRACE_CYC = 8
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	output logic char_tick_o,
	output logic hretrace_o
);
	int pos;
	// Outputs change at the falling edge, away from the sampling edge.
	always @(negedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pos <= 0;
			char_tick_o <= 1'b0;
			hretrace_o <= 1'b0;
		end else begin
			pos <= (pos == LINE_CYC - 1) ? 0 : pos + 1;
			char_tick_o <= (pos % TICK_DIV) == 0;
			hretrace_o <= pos < RETRACE_CYC;
		end
	end
endmodule : cvt_raster_model

// ### verification/testbench.sv
// Self-checking bench for the vertical timing block.
`timescale 1ns/1ps
module testbench;
	import cvt_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	cvt_req_t req = '0;
	logic [7:0] ext_lock = 8'h00;
	logic legacy = 1'b0;
	logic [13:0] lpen = 14'h0000;
	logic char_tick, hretrace, hsync, vsync, vblank, vdisp, irq, refresh, underline;
	logic [15:0] mem_addr;
	logic [7:0] rdata;
	logic [31:0] seed = 32'hd741b41a;
	logic [7:0] model [0:31];
	logic [7:0] idx_tab [0:10] = '{8'h06, 8'h07, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
	logic [7:0] prog_idx [0:11] = '{8'h06, 8'h07, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h17};
	logic [7:0] prog_val [0:11] = '{8'h0a, 8'h00, 8'h01, 8'h06, 8'h18, 8'h04, 8'h00, 8'h01, 8'h08, 8'h0b, 8'hff, 8'h80};
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	int cnt [0:7];
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	cvt_raster_model i_raster (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .char_tick_o(char_tick),
		.hretrace_o(hretrace));
	cvt_vtiming i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(req), .ext_lock_i(ext_lock),
		.legacy_mode_i(legacy), .lpen_i(lpen), .char_tick_i(char_tick), .hretrace_i(hretrace), .rdata_o(rdata),
		.hsync_o(hsync), .vsync_o(vsync), .vblank_o(vblank), .vdisp_o(vdisp), .irq_o(irq), .refresh_o(refresh),
		.underline_o(underline), .mem_addr_o(mem_addr));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	function automatic logic [7:0] exp_rd(input logic [7:0] idx);
		if (legacy && idx == 8'h10) return {2'b00, lpen[13:8]};
		if (legacy && idx == 8'h11) return lpen[7:0];
		if (idx == 8'h06 || idx == 8'h07 || idx == 8'h09 || (idx >= 8'h10 && idx <= 8'h18)) return model[idx[4:0]];
		return 8'h00;
	endfunction : exp_rd
	function automatic logic [7:0] after_wr(input logic [7:0] idx, input logic [7:0] val);
		logic [7:0] old;
		old = model[idx[4:0]];
		if (idx <= 8'h07 && model[8'h11][7]) return (idx == 8'h07) ? {old[7:5], val[4], old[3:0]} : old;
		if ((idx == 8'h12 || idx == 8'h15 || idx == 8'h16) && ext_lock[0]) return old;
		if (idx == 8'h17 && ext_lock[5]) return old;
		return val;
	endfunction : after_wr
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic access(input logic [7:0] idx, input logic [7:0] val, input logic rd);
		@(negedge clk_sys_i);
		req <= '{index_wr: 1'b1, data_wr: 1'b0, data_rd: 1'b0, wdata: idx};
		@(negedge clk_sys_i);
		req <= '{index_wr: 1'b0, data_wr: !rd, data_rd: rd, wdata: val};
		@(negedge clk_sys_i);
		req <= '0;
		@(negedge clk_sys_i);
	endtask : access
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		if (idx <= 8'h18) model[idx[4:0]] = after_wr(idx, val);
		access(idx, val, 1'b0);
	endtask : wr
	task automatic rd_check(input logic [7:0] idx);
		access(idx, 8'h00, 1'b1);
		check({8'h00, rdata}, {8'h00, exp_rd(idx)});
	endtask : rd_check
	task automatic measure(input int n);
		cnt = '{0, 0, 0, 0, 0, 0, 0, 0};
		repeat (n) begin
			@(negedge clk_sys_i);
			cnt[0] += int'(hsync === 1'b1);
			cnt[1] += int'(vsync === 1'b1);
			cnt[2] += int'(vblank === 1'b1);
			cnt[3] += int'(vdisp === 1'b1);
			cnt[4] += int'(refresh === 1'b1);
			cnt[5] += int'(underline === 1'b1);
			cnt[6] += int'(mem_addr[13] === 1'b1);
			cnt[7] += int'(mem_addr[12:0]);
		end
	endtask : measure
	task automatic print_verdict();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 40000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		for (int i = 0; i < 32; i++) model[i] = 8'h00;
		repeat (4) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
		for (int i = 0; i < 32; i++) rd_check(8'(i));
		for (int i = 0; i < 40; i++) begin
			seed = xorshift(seed);
			wr(idx_tab[seed[15:8] % 11], (idx_tab[seed[15:8] % 11] == 8'h11) ? {1'b0, seed[6:0]} : seed[7:0]);
			rd_check(idx_tab[seed[15:8] % 11]);
		end
		wr(8'h11, 8'h80);
		wr(8'h06, ~model[6]);
		wr(8'h07, ~model[7]);
		rd_check(8'h06);
		rd_check(8'h07);
		wr(8'h11, 8'h00);
		ext_lock = 8'h21;
		foreach (prog_idx[i]) begin
			seed = xorshift(seed);
			wr(prog_idx[i], seed[7:0]);
			rd_check(prog_idx[i]);
		end
		ext_lock = 8'h00;
		legacy = 1'b1;
		seed = xorshift(seed);
		lpen = seed[13:0];
		rd_check(8'h10);
		rd_check(8'h11);
		legacy = 1'b0;
		// A second reset brings the line counter back inside the frame programmed below.
		arst_n_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		arst_n_i = 1'b1;
		for (int i = 0; i < 32; i++) model[i] = 8'h00;
		rd_check(8'h17);
		foreach (prog_idx[i]) wr(prog_idx[i], prog_val[i]);
		measure(480);
		measure(960);
		check(16'(cnt[0]), 16'd192);
		check(16'(cnt[1]), 16'd160);
		check(16'(cnt[2]), 16'd160);
		check(16'(cnt[3]), 16'd400);
		check(16'(cnt[4]), 16'd72);
		check(16'(cnt[5]), 16'd480);
		check(16'(cnt[6]), 16'd160);
		check(16'(cnt[7]), 16'd8640);
		check({15'h0, irq}, 16'h1);
		wr(8'h11, 8'h08);
		check({15'h0, irq}, 16'h0);
		measure(600);
		check({15'h0, irq}, 16'h0);
		wr(8'h11, 8'h38);
		measure(600);
		check({15'h0, irq}, 16'h0);
		wr(8'h11, 8'h18);
		check({15'h0, irq}, 16'h1);
		wr(8'h11, 8'h58);
		measure(40);
		measure(960);
		check(16'(cnt[4]), 16'd120);
		wr(8'h17, 8'h84);
		measure(960);
		measure(960);
		check(16'(cnt[3]), 16'd400);
		check(16'(cnt[1]), 16'd160);
		// byte mode with row pitch one and count by two.
		wr(8'h13, 8'h01);
		wr(8'h17, 8'hc8);
		measure(480);
		measure(960);
		check(16'(cnt[7]), 16'd6720);
		check(16'(cnt[6]), 16'd160);
		wr(8'h17, 8'h00);
		measure(960);
		check(16'(cnt[0]), 16'd0);
		check(16'(cnt[1]), 16'd0);
		print_verdict();
	end
endmodule : testbench
